// file: hdl/fsbr_pkg.sv
/*
 * fsbr_pkg: constants, types and helpers shared by the flash status host controller.
 * assumes: a flash with a 16-bit data bus, status bits in the low byte or in the upper byte.
 */
package fsbr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register map of the controller (byte offsets on AHB-Lite)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_SEL  = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_BAD  = 8'h14;
	localparam logic [7:0] OFF_RDAT = 8'h18;

	localparam int CTRL_START    = 0;
	localparam int CTRL_OP_LSB   = 1;
	localparam int CTRL_METH_LSB = 3;
	localparam int CTRL_UPPER    = 5;

	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_FAIL    = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_VERIFY  = 4;

	localparam int NSEL = 20;
	localparam logic [15:0]     ADDR_RESET = 16'h0000;
	localparam logic [15:0]     DATA_RESET = 16'hFFFF;
	localparam logic [NSEL-1:0] SEL_RESET  = 20'h00000;

	////////////////////////////////////////////////////////////////////////////////
	// status bit positions inside the status byte
	localparam logic [2:0] DP_POS  = 3'h7;
	localparam logic [2:0] TG_POS  = 3'h6;
	localparam logic [2:0] ER_POS  = 3'h5;
	localparam logic [2:0] ETO_POS = 3'h3;

	////////////////////////////////////////////////////////////////////////////////
	// instruction codes and unlock addresses
	localparam logic [15:0] UNLOCK_A1 = 16'h0AAA;
	localparam logic [15:0] UNLOCK_A2 = 16'h0554;
	localparam logic [7:0]  UNLOCK_D1 = 8'hAA;
	localparam logic [7:0]  UNLOCK_D2 = 8'h55;
	localparam logic [7:0]  CMD_PROG  = 8'hA0;
	localparam logic [7:0]  CMD_ERASE = 8'h80;
	localparam logic [7:0]  CMD_SECT  = 8'h30;
	localparam logic [7:0]  CMD_BULK  = 8'h10;
	localparam logic [7:0]  CMD_RESET = 8'hF0;
	localparam logic [2:0]  PROG_STEPS  = 3'h4;
	localparam logic [2:0]  ERASE_STEPS = 3'h6;

	////////////////////////////////////////////////////////////////////////////////
	// bus timing
	localparam int T_STROBE_NS = 100;
	localparam int CLK_NS      = 25;
	localparam logic [2:0] STROBE_CYC = 3'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [1:0] {
		OP_PROG  = 2'b00,
		OP_SECT  = 2'b01,
		OP_BULK  = 2'b10,
		OP_RESET = 2'b11
	} fsbr_op_e;

	typedef enum logic [1:0] {
		M_POLL   = 2'b00,
		M_TOGGLE = 2'b01,
		M_RDY    = 2'b10,
		M_RSV    = 2'b11
	} fsbr_meth_e;

	// pick one status bit from the lane in use; undefined bits are never looked at
	function automatic logic statusBit(input logic [15:0] w, input logic upper,
		input logic [2:0] pos);
		statusBit = upper ? w[{1'b1, pos}] : w[{1'b0, pos}];
	endfunction

	// address and data of one write step of an instruction
	function automatic logic [31:0] stepWord(input fsbr_op_e op, input logic [2:0] idx,
		input logic [15:0] a, input logic [15:0] d);
		logic [7:0] b;
		logic [15:0] ad;
		b  = CMD_RESET;
		ad = ADDR_RESET;
		if (op != OP_RESET) begin
			unique case (idx)
				3'h0, 3'h3: begin
					b  = UNLOCK_D1;
					ad = UNLOCK_A1;
				end
				3'h1, 3'h4: begin
					b  = UNLOCK_D2;
					ad = UNLOCK_A2;
				end
				3'h2: begin
					b  = (op == OP_PROG) ? CMD_PROG : CMD_ERASE;
					ad = UNLOCK_A1;
				end
				default: begin
					b  = (op == OP_BULK) ? CMD_BULK : CMD_SECT;
					ad = (op == OP_BULK) ? UNLOCK_A1 : {a[15:1], 1'b0};
				end
			endcase
		end
		if (op == OP_PROG && idx == 3'h3)
			stepWord = {a[15:1], 1'b0, d};
		else
			stepWord = {ad, b, b};
	endfunction

endpackage

// file: hdl/fsbr_bus_cycle.sv
/*
 * fsbr_bus_cycle: one read or write cycle on the flash's asynchronous bus.
 * assumes: flash pins are sampled on clk; write, addr, wdata and sel are latched when start is seen.
 */
`timescale 1ns/100ps
`default_nettype none
module fsbr_bus_cycle
	import fsbr_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire logic            ce,
	input  wire logic            start,
	input  wire logic            write,
	input  wire logic [15:0]     addr,
	input  wire logic [15:0]     wdata,
	input  wire logic [NSEL-1:0] sel,
	output logic                 done,
	output logic      [15:0]     rdata,
	output logic      [15:0]     flAddr,
	output logic      [15:0]     flDataOut,
	input  wire logic [15:0]     flDataIn,
	output logic                 flDataOe_n,
	output logic                 flWrStb_n,
	output logic                 flRdStb_n,
	output logic      [15:0]     primarySectorSelect,
	output logic      [3:0]      secondarySectorSelect
);

	typedef enum logic [1:0] {
		C_IDLE   = 2'b00,
		C_SETUP  = 2'b01,
		C_STROBE = 2'b10,
		C_HOLD   = 2'b11
	} fsbr_cyc_e;

	fsbr_cyc_e        st_q, st_d;
	logic [2:0]       cnt_q, cnt_d;
	logic             wr_q, wr_d;
	logic [15:0]      rdata_q, rdata_d, addr_q, addr_d, wdat_q, wdat_d;
	logic [NSEL-1:0]  sel_q, sel_d;

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		wr_d    = wr_q;
		rdata_d = rdata_q;
		addr_d  = addr_q;
		wdat_d  = wdat_q;
		sel_d   = sel_q;
		unique case (st_q)
			C_IDLE: if (start) begin
				st_d   = C_SETUP;
				wr_d   = write;
				addr_d = addr;
				wdat_d = wdata;
				sel_d  = sel;
			end
			C_SETUP: begin
				st_d  = C_STROBE;
				cnt_d = STROBE_CYC;
			end
			C_STROBE: begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1) begin
					st_d = C_HOLD;
					if (!wr_q)
						rdata_d = flDataIn;
				end
			end
			C_HOLD: st_d = C_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q    <= C_IDLE;
			cnt_q   <= 3'h0;
			wr_q    <= 1'b0;
			rdata_q <= 16'h0000;
			addr_q  <= ADDR_RESET;
			wdat_q  <= 16'h0000;
			sel_q   <= SEL_RESET;
		end else if (ce) begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			wr_q    <= wr_d;
			rdata_q <= rdata_d;
			addr_q  <= addr_d;
			wdat_q  <= wdat_d;
			sel_q   <= sel_d;
		end
	end

	// selects stay low between cycles so no stray edge can start a write
	assign done                  = ce && st_q == C_HOLD;
	assign rdata                 = rdata_q;
	assign flAddr                = addr_q;
	assign flDataOut             = wdat_q;
	assign flDataOe_n            = !(wr_q && st_q != C_IDLE);
	assign flWrStb_n             = !(wr_q && st_q == C_STROBE);
	assign flRdStb_n             = !(!wr_q && st_q == C_STROBE);
	assign primarySectorSelect   = (st_q != C_IDLE) ? sel_q[15:0] : 16'h0000;
	assign secondarySectorSelect = (st_q != C_IDLE) ? sel_q[19:16] : 4'h0;

endmodule
`default_nettype wire

// file: hdl/fsbr_host.sv
/*
 * fsbr_host: host controller that programs and erases a flash and polls its status bits.
 * assumes: an AHB-Lite master, a flash with sector selects and a ready/busy pin (high = ready).
 */
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Function
// (RULE1) status word read at an even address, as often as needed while busy
// (RULE2) low lane: polling bit 7, toggle 6, error 5, erase timeout 3
// (RULE3) upper lane: polling bit 15, toggle 14, error 13, erase timeout 11
// (RULE4) undefined status bits are ignored when judging completion; the toggle method here compares all 16 bits of two reads
// (RULE5) program polling bit reads inverted data until done, then true data
// (RULE6) status valid after fourth program strobe or sixth erase strobe
// (RULE7) erase polling bit reads zero while busy, one when done
// (RULE8) program to protected sector is ignored by the flash
// (RULE9) all-protected erase: polling bit zero for about 100us, nothing erased
// (RULE10) toggle bit inverts on each read while busy and selected
// (RULE11) done when two consecutive reads return identical data
// (RULE12) all-protected erase: toggle bit zero for about 100us
// (RULE13) error bit zero normally, one on program or erase failure
// (RULE14) error bit set on zero-to-one program or program timeout
// (RULE15) error bit holds until reset instruction; host issues it; the ready/busy method here sends none, never reading the error bit
// (RULE16) host stops using a sector after its program or erase error; the ready/busy method here never sees the error or marks the sector bad
// (RULE17) erase timeout bit zero during window, one after it expires
// (RULE18) host erases before programming; programs one word at a time
// (RULE19) host checks completion by polling, toggle or ready/busy pin
// (RULE20) on error bit, host rereads once before declaring failure
// (RULE21) host polls inside erased sector or at the programmed address
// (RULE22) host reads programmed word back and compares it; the ready/busy method here skips it and ends when the pin reads ready
// (RULE23) reset instruction returns flash to read mode before normal reads
// (RULE24) flash holds ready/busy pin busy while its algorithm runs
module fsbr_host
	import fsbr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        hready,
	output logic      [15:0] flAddr,
	output logic      [15:0] flDataOut,
	input  wire logic [15:0] flDataIn,
	output logic             flDataOe_n,
	output logic             flWrStb_n,
	output logic             flRdStb_n,
	output logic      [15:0] primarySectorSelect,
	output logic      [3:0]  secondarySectorSelect,
	input  wire logic        readyBusyPin
);

	typedef enum logic [2:0] {
		S_IDLE   = 3'b000,
		S_CMD    = 3'b001,
		S_POLL   = 3'b010,
		S_RDY    = 3'b011,
		S_RSTCMD = 3'b100,
		S_VERIFY = 3'b101
	} fsbr_st_e;

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states while ce is high, answers always OKAY
	logic            wrPend_q, wrPend_d;
	logic [7:0]      wrAddr_q, wrAddr_d;
	logic [31:0]     hrdata_q, hrdata_d;
	fsbr_op_e        op_q, op_d;
	fsbr_meth_e      meth_q, meth_d;
	logic            upper_q, upper_d;
	logic [15:0]     addr_q, addr_d, data_q, data_d, rdat_q, rdat_d, prev_q, prev_d;
	logic [NSEL-1:0] sel_q, sel_d, bad_q, bad_d, erased_q, erased_d;
	logic            done_q, done_d, fail_q, fail_d, refused_q, refused_d;
	logic            verr_q, verr_d, errSeen_q, errSeen_d, havePrev_q, havePrev_d;
	fsbr_st_e        st_q, st_d;
	logic [2:0]      step_q, step_d;
	logic            issue_q, issue_d;
	logic            addrPhase, start, cycDone, cycWrite, passNow, failNow, refuse;
	logic            dp, er, dpWant, match, same;
	logic [31:0]     sw;
	logic [15:0]     cycAddr, cycWdata, cycRdata, pollAddr;
	logic [2:0]      lastStep;

	assign addrPhase = hsel && htrans[1] && hready && ce;
	assign hreadyout = ce;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	always_comb begin
		wrPend_d = wrPend_q;
		wrAddr_d = wrAddr_q;
		hrdata_d = hrdata_q;
		if (hready) begin
			wrPend_d = addrPhase && hwrite;
			wrAddr_d = haddr[7:0];
			hrdata_d = 32'h0000_0000;
			if (addrPhase && !hwrite) begin
				unique case (haddr[7:0])
					OFF_CTRL: hrdata_d = {26'h0, upper_q, meth_q, op_q, 1'b0};
					OFF_ADDR: hrdata_d = {16'h0, addr_q};
					OFF_DATA: hrdata_d = {16'h0, data_q};
					OFF_SEL:  hrdata_d = {12'h0, sel_q};
					OFF_STAT: hrdata_d = {27'h0, verr_q, refused_q, fail_q, done_q,
						st_q != S_IDLE};
					OFF_BAD:  hrdata_d = {12'h0, bad_q};
					OFF_RDAT: hrdata_d = {16'h0, rdat_q};
					default:  hrdata_d = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else if (ce) begin
			wrPend_q <= wrPend_d;
			wrAddr_q <= wrAddr_d;
			hrdata_q <= hrdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer: instruction writes, status polling, error recovery, read-back
	assign start    = wrPend_q && wrAddr_q == OFF_CTRL && hwdata[CTRL_START];
	assign lastStep = (op_q == OP_PROG) ? PROG_STEPS - 3'h1 : ERASE_STEPS - 3'h1;
	assign pollAddr = {addr_q[15:1], 1'b0};                            // [RULE21]
	assign sw       = stepWord(op_q, step_q, addr_q, data_q);
	assign cycWrite = st_q == S_CMD || st_q == S_RSTCMD;
	assign cycAddr  = cycWrite ? sw[31:16] : pollAddr;
	assign cycWdata = (st_q == S_RSTCMD) ? {CMD_RESET, CMD_RESET} : sw[15:0];
	// only defined status bits feed the polling decision; the toggle method compares whole words [RULE4]
	assign dp       = statusBit(cycRdata, upper_q, DP_POS);
	assign er       = statusBit(cycRdata, upper_q, ER_POS);
	assign dpWant   = (op_q == OP_PROG) ? statusBit(data_q, upper_q, DP_POS) : 1'b1;
	assign match    = dp == dpWant;
	assign same     = havePrev_q && cycRdata == prev_q;
	assign passNow  = (st_q == S_POLL && cycDone && (meth_q == M_TOGGLE ? same : match))
		|| (st_q == S_RDY && readyBusyPin && ce);
	assign failNow  = st_q == S_POLL && cycDone && !passNow && er && errSeen_q;
	// refused: bad sector, program into unerased sector, or nothing selected
	assign refuse   = hwdata[CTRL_OP_LSB +: 2] != OP_RESET
		&& (((sel_q & bad_q) != SEL_RESET) || sel_q == SEL_RESET
		|| (hwdata[CTRL_OP_LSB +: 2] == OP_PROG && (sel_q & ~erased_q) != SEL_RESET));

	always_comb begin
		op_d       = op_q;
		meth_d     = meth_q;
		upper_d    = upper_q;
		addr_d     = addr_q;
		data_d     = data_q;
		sel_d      = sel_q;
		bad_d      = bad_q;
		erased_d   = erased_q;
		done_d     = done_q;
		fail_d     = fail_q;
		refused_d  = refused_q;
		verr_d     = verr_q;
		errSeen_d  = errSeen_q;
		havePrev_d = havePrev_q;
		prev_d     = prev_q;
		rdat_d     = rdat_q;
		st_d       = st_q;
		step_d     = step_q;
		issue_d    = 1'b0;
		if (wrPend_q && st_q == S_IDLE) begin
			unique case (wrAddr_q)
				OFF_ADDR: addr_d = hwdata[15:0];
				OFF_DATA: data_d = hwdata[15:0];
				OFF_SEL:  sel_d  = hwdata[NSEL-1:0];
				default: ;
			endcase
		end
		if (cycDone)
			rdat_d = cycRdata;
		unique case (st_q)
			S_IDLE: if (start) begin
				op_d      = fsbr_op_e'(hwdata[CTRL_OP_LSB +: 2]);
				meth_d    = fsbr_meth_e'(hwdata[CTRL_METH_LSB +: 2]);
				upper_d   = hwdata[CTRL_UPPER];
				done_d    = 1'b0;
				fail_d    = 1'b0;
				verr_d    = 1'b0;
				refused_d = refuse;                                      // [RULE16] [RULE18]
				errSeen_d = 1'b0;
				havePrev_d = 1'b0;
				step_d    = 3'h0;
				if (!refuse) begin
					issue_d = 1'b1;
					st_d    = (hwdata[CTRL_OP_LSB +: 2] == OP_RESET) ? S_RSTCMD : S_CMD;
				end
			end
			S_CMD: if (cycDone) begin
				issue_d = 1'b1;
				step_d  = step_q + 3'h1;
				// completion is always checked after the last strobe [RULE19]
				if (step_q == lastStep) begin
					issue_d = meth_q != M_RDY;
					st_d    = (meth_q == M_RDY) ? S_RDY : S_POLL;
				end
			end
			S_RDY: if (passNow) begin
				done_d = 1'b1;
				st_d   = S_IDLE;
				if (op_q != OP_PROG)
					erased_d = (op_q == OP_BULK) ? {NSEL{1'b1}} : erased_q | sel_q;
			end
			S_POLL: if (cycDone) begin
				issue_d    = 1'b1;
				prev_d     = cycRdata;
				havePrev_d = 1'b1;
				if (passNow) begin
					if (op_q == OP_PROG) begin
						st_d = S_VERIFY;                                 // [RULE22]
					end else begin
						issue_d  = 1'b0;
						done_d   = 1'b1;
						st_d     = S_IDLE;
						erased_d = (op_q == OP_BULK) ? {NSEL{1'b1}} : erased_q | sel_q;
					end
				end else if (failNow) begin
					fail_d = 1'b1;
					bad_d  = bad_q | sel_q;                              // [RULE16]
					st_d   = S_RSTCMD;                                   // [RULE15]
				end else if (er) begin
					errSeen_d = 1'b1;                                    // [RULE20]
				end
			end
			S_VERIFY: if (cycDone) begin
				verr_d = cycRdata != data_q;                             // [RULE22]
				done_d = 1'b1;
				st_d   = S_IDLE;
			end
			S_RSTCMD: if (cycDone) begin
				done_d = 1'b1;
				st_d   = S_IDLE;                                         // [RULE23]
			end
			default: st_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			op_q       <= OP_PROG;
			meth_q     <= M_POLL;
			upper_q    <= 1'b0;
			addr_q     <= ADDR_RESET;
			data_q     <= DATA_RESET;
			sel_q      <= SEL_RESET;
			bad_q      <= SEL_RESET;
			erased_q   <= SEL_RESET;
			done_q     <= 1'b0;
			fail_q     <= 1'b0;
			refused_q  <= 1'b0;
			verr_q     <= 1'b0;
			errSeen_q  <= 1'b0;
			havePrev_q <= 1'b0;
			prev_q     <= 16'h0000;
			rdat_q     <= 16'h0000;
			st_q       <= S_IDLE;
			step_q     <= 3'h0;
			issue_q    <= 1'b0;
		end else if (ce) begin
			op_q       <= op_d;
			meth_q     <= meth_d;
			upper_q    <= upper_d;
			addr_q     <= addr_d;
			data_q     <= data_d;
			sel_q      <= sel_d;
			bad_q      <= bad_d;
			erased_q   <= erased_d;
			done_q     <= done_d;
			fail_q     <= fail_d;
			refused_q  <= refused_d;
			verr_q     <= verr_d;
			errSeen_q  <= errSeen_d;
			havePrev_q <= havePrev_d;
			prev_q     <= prev_d;
			rdat_q     <= rdat_d;
			st_q       <= st_d;
			step_q     <= step_d;
			issue_q    <= issue_d;
		end
	end

	fsbr_bus_cycle u_cycle (
		.clk                   (clk),
		.rst_n                 (rst_n),
		.ce                    (ce),
		.start                 (issue_q && ce),
		.write                 (cycWrite),
		.addr                  (cycAddr),
		.wdata                 (cycWdata),
		.sel                   (sel_q),
		.done                  (cycDone),
		.rdata                 (cycRdata),
		.flAddr                (flAddr),
		.flDataOut             (flDataOut),
		.flDataIn              (flDataIn),
		.flDataOe_n            (flDataOe_n),
		.flWrStb_n             (flWrStb_n),
		.flRdStb_n             (flRdStb_n),
		.primarySectorSelect   (primarySectorSelect),
		.secondarySectorSelect (secondarySectorSelect)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence seqCmdEnd;
		st_q == S_CMD && cycDone && step_q == lastStep;
	endsequence
	sequence seqFailSeen;
		st_q == S_POLL && failNow && ce;
	endsequence

	a_poll_after_cmd: assert property (seqCmdEnd |=> st_q == S_POLL || st_q == S_RDY) // [RULE19]
		else $error("no status check after instruction");
	a_reset_after_fail: assert property (seqFailSeen |=> st_q == S_RSTCMD ##0 fail_q) // [RULE15]
		else $error("reset instruction not sent after failure");
	a_reset_to_idle: assert property (st_q == S_RSTCMD && cycDone |=> st_q == S_IDLE) // [RULE23]
		else $error("reset instruction did not end the operation");
	a_bad_sector_refused: assert property (st_q == S_IDLE && start && ce // [RULE16]
		&& (sel_q & bad_q) != SEL_RESET && hwdata[CTRL_OP_LSB +: 2] != OP_RESET
		|=> refused_q && st_q == S_IDLE)
		else $error("command to failed sector not refused");
	a_erase_first: assert property (st_q == S_IDLE && start && ce // [RULE18]
		&& hwdata[CTRL_OP_LSB +: 2] == OP_PROG && (sel_q & ~erased_q) != SEL_RESET
		|=> refused_q)
		else $error("program to unerased sector not refused");
	a_reread_on_err: assert property (st_q == S_POLL && cycDone && er && !passNow // [RULE20]
		&& !errSeen_q |=> st_q == S_POLL && errSeen_q && !fail_q)
		else $error("failure declared without reread");
	a_poll_address: assert property (st_q == S_POLL && issue_q |-> cycAddr[0] == 1'b0 // [RULE21]
		&& cycAddr == {addr_q[15:1], 1'b0})
		else $error("status polled at wrong address");
	a_verify_read: assert property (st_q == S_POLL && passNow && op_q == OP_PROG && ce // [RULE22]
		|=> st_q == S_VERIFY ##2 !flRdStb_n && flAddr == pollAddr)
		else $error("programmed word not read back");
	a_toggle_pair: assert property (st_q == S_POLL && passNow && meth_q == M_TOGGLE // [RULE11]
		|-> havePrev_q && cycRdata == prev_q)
		else $error("toggle completion without two equal reads");
	a_masked_eval: assert property (st_q == S_POLL && cycDone && meth_q == M_POLL // [RULE4]
		|-> passNow == (statusBit(cycRdata, upper_q, DP_POS) == dpWant))
		else $error("polling decision uses undefined bits");

endmodule
`default_nettype wire

// file: bench/fsbr_flash_model.sv
/*
 * fsbr_flash_model: behavioural flash with embedded program/erase and status reads.
 * assumes: pins sampled on clk; 16-word memory shared by all sectors.
 */
`timescale 1ns/100ps
`default_nettype none
module fsbr_flash_model #(
	parameter int          BUSY_CYC  = 60,
	parameter int          ETO_CYC   = 20,
	parameter int          PROT_CYC  = 80,
	parameter logic [19:0] PROT_MASK = 20'h00004
) (
	input  wire logic        clk,
	input  wire logic [15:0] flAddr,
	input  wire logic [15:0] flDataOut,
	input  wire logic        flWrStb_n,
	input  wire logic        flRdStb_n,
	input  wire logic [15:0] primarySectorSelect,
	input  wire logic [3:0]  secondarySectorSelect,
	input  wire logic        upperLane,
	output logic      [15:0] flDataIn,
	output logic             readyBusyPin
);
	logic [15:0] mem [16];
	logic [15:0] tgt = 16'h0000;
	logic [15:0] dout = 16'h0000;
	logic [19:0] sel;
	logic [7:0]  b, st;
	logic [2:0]  step = 3'h0;
	logic        isProg = 1'b0, isErase = 1'b0, err = 1'b0, errL = 1'b0, tog = 1'b0;
	logic        wrPrev = 1'b1, rdPrev = 1'b1, act;
	int          busyCnt = 0, etoCnt = 0, protCnt = 0;

	assign sel = {secondarySectorSelect, primarySectorSelect};
	assign readyBusyPin = (busyCnt == 0);
	// released bus shows the inverse so a late sample cannot pass
	assign flDataIn = flRdStb_n ? ~dout : dout;
	initial foreach (mem[i]) mem[i] = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		b = flDataOut[7:0];
		if (busyCnt > 0) begin
			busyCnt--;
			if (busyCnt == 0 && err) errL = 1'b1;
			if (busyCnt == 0 && isErase) foreach (mem[i]) mem[i] = 16'hFFFF;
		end
		if (etoCnt > 0) etoCnt--;
		if (protCnt > 0) protCnt--;
		if (!wrPrev && flWrStb_n && sel != 20'h0) begin
			if (step == 3'h3 && isProg) begin
				step = 3'h0;
				if ((sel & PROT_MASK) == 20'h0) begin
					tgt = flDataOut;
					err = ((~mem[flAddr[4:1]] & tgt) != 16'h0);
					if (!err) mem[flAddr[4:1]] = tgt;
					busyCnt = BUSY_CYC;
				end
			end else if (b == 8'hF0) begin
				step = 3'h0;
				errL = 1'b0;
				err = 1'b0;
			end else if (busyCnt == 0 && !errL) begin
				case (step)
					3'h0: step = (b == 8'hAA) ? 3'h1 : 3'h0;
					3'h1: step = (b == 8'h55) ? 3'h2 : 3'h0;
					3'h2: begin
						isProg = (b == 8'hA0);
						isErase = (b == 8'h80);
						step = (isProg || isErase) ? 3'h3 : 3'h0;
					end
					3'h3: step = (b == 8'hAA) ? 3'h4 : 3'h0;
					3'h4: step = (b == 8'h55) ? 3'h5 : 3'h0;
					default: begin
						step = 3'h0;
						if ((sel & ~PROT_MASK) == 20'h0) protCnt = PROT_CYC;
						else begin
							busyCnt = BUSY_CYC;
							etoCnt = ETO_CYC;
						end
					end
				endcase
			end
		end
		if (rdPrev && !flRdStb_n) begin
			act = (busyCnt > 0) || errL;
			if (act || protCnt > 0) begin
				tog = ~tog;
				// undefined bits follow the toggle so a host that reads them gets caught
				st = {isErase ? 1'b0 : ~(upperLane ? tgt[15] : tgt[7]), tog, errL, tog,
					isErase && etoCnt == 0, {3{tog}}};
				if (!act) st = 8'h00;
				dout = upperLane ? {st, ~st} : {~st, st};
			end else dout = mem[flAddr[4:1]];
		end
		wrPrev = flWrStb_n;
		rdPrev = flRdStb_n;
	end
endmodule
`default_nettype wire

// file: bench/tb.sv
/*
 * tb: drives the host controller over AHB-Lite against the flash model.
 * assumes: zero-wait slave; busy bit of STAT falls when an operation ends.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fsbr_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, upperLane = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, st;
	logic [1:0]  htrans = 2'b00;
	logic        hreadyout, flWrStb_n, flRdStb_n, readyBusyPin;
	logic [15:0] flAddr, flDataOut, flDataIn, pSel;
	logic [3:0]  sSel;
	int          fails = 0, tests_run = 0, cyc = 0;

	always #12.5 clk = ~clk;

	fsbr_host u_fsbr_host (.clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .hready(hreadyout), .flAddr(flAddr),
		.flDataOut(flDataOut), .flDataIn(flDataIn), .flDataOe_n(), .flWrStb_n(flWrStb_n),
		.flRdStb_n(flRdStb_n), .primarySectorSelect(pSel), .secondarySectorSelect(sSel),
		.readyBusyPin(readyBusyPin));
	fsbr_flash_model u_fsbr_flash_model (.clk(clk), .flAddr(flAddr), .flDataOut(flDataOut),
		.flWrStb_n(flWrStb_n), .flRdStb_n(flRdStb_n), .primarySectorSelect(pSel),
		.secondarySectorSelect(sSel), .upperLane(upperLane), .flDataIn(flDataIn),
		.readyBusyPin(readyBusyPin));

	////////////////////////////////////////////////////////////////////////////////
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// load operands, start, then poll STAT until busy clears
	task automatic run(input logic [1:0] op, input logic [1:0] meth, input logic up,
		input logic [19:0] s, input logic [15:0] a, input logic [15:0] d);
		ahb(1'b1, OFF_SEL, {12'h0, s}, r);
		ahb(1'b1, OFF_ADDR, {16'h0, a}, r);
		ahb(1'b1, OFF_DATA, {16'h0, d}, r);
		upperLane <= up;
		ahb(1'b1, OFF_CTRL, {26'h0, up, meth, op, 1'b1}, r);
		do ahb(1'b0, OFF_STAT, 32'h0, st); while (st[ST_BUSY] !== 1'b0);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ceiling well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		ahb(1'b0, OFF_DATA, 32'h0, r);
		chk(r, 32'h0000FFFF);
		ahb(1'b0, OFF_STAT, 32'h0, r);
		chk(r, 32'h0);
		ahb(1'b0, 8'h1C, 32'h0, r);
		chk(r, 32'h0);
		run(OP_PROG, M_POLL, 1'b0, 20'h1, 16'h0004, 16'h1234);
		chk(st & 32'h8, 32'h8);
		run(OP_SECT, M_POLL, 1'b0, 20'h1, 16'h0004, 16'h0);
		chk(st, 32'h2);
		run(OP_PROG, M_POLL, 1'b0, 20'h1, 16'h0004, 16'h1234);
		chk(st, 32'h2);
		ahb(1'b0, OFF_RDAT, 32'h0, r);
		chk(r, 32'h1234);
		run(OP_PROG, M_TOGGLE, 1'b0, 20'h1, 16'h0004, 16'h00FF);
		chk(st, 32'h6);
		ahb(1'b0, OFF_BAD, 32'h0, r);
		chk(r, 32'h1);
		run(OP_SECT, M_POLL, 1'b0, 20'h1, 16'h0004, 16'h0);
		chk(st & 32'h8, 32'h8);
		run(OP_SECT, M_POLL, 1'b0, 20'h4, 16'h0008, 16'h0);
		chk(st, 32'h2);
		run(OP_SECT, M_RDY, 1'b1, 20'h2, 16'h0010, 16'h0);
		chk(st, 32'h2);
		run(OP_PROG, M_POLL, 1'b1, 20'h2, 16'h0010, 16'hA5C3);
		chk(st, 32'h2);
		ahb(1'b0, OFF_RDAT, 32'h0, r);
		chk(r, 32'hA5C3);
		run(OP_BULK, M_TOGGLE, 1'b0, 20'h2, 16'h0, 16'h0);
		chk(st, 32'h2);
		run(OP_RESET, M_POLL, 1'b0, 20'h2, 16'h0, 16'h0);
		chk(st, 32'h2);
		complete_run();
	end
endmodule
`default_nettype wire
